// *** pdwc_asserts.sv ***
`timescale 1ns/1ps
`include "pdwc_regs.vh"

module pdwc_asserts (
	input wire                    clk_sys,
	input wire                    rstn,
	input wire                    s_axi_awvalid,
	input wire                    s_axi_awready,
	input wire                    s_axi_bvalid,
	input wire                    s_axi_bready,
	input wire                    s_axi_arvalid,
	input wire                    s_axi_arready,
	input wire [`PDWC_ADDR_W-1:0] s_axi_araddr,
	input wire                    s_axi_rvalid,
	input wire                    s_axi_rready,
	input wire                    bus_supply,
	input wire                    onoff_on,
	input wire                    cpu_halted,
	input wire                    clocks_run_q,
	input wire                    analog_shutdown_q,
	input wire                    boost_stop_q,
	input wire                    slow_osc_enable_q,
	input wire                    fast_osc_enable_q,
	input wire                    card_power_off_q,
	input wire                    wake_interrupt_line_q
);
	localparam [17:0] EXT = {`PDWC_IDX_EXT_CTRL, 2'h0};
	reg [9:0] run_q;
	reg [5:0] gap_q;

	// Cycles of running clocks, and cycles since the last write response.
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			run_q <= 10'h000;
			gap_q <= 6'h00;
		end
		else
		begin
			run_q <= !clocks_run_q ? 10'h000 : run_q + {9'h000, run_q != 10'h3ff};
			gap_q <= (s_axi_bvalid && s_axi_bready) ? 6'h00 : gap_q + {5'h00, gap_q != 6'h3f};
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////////////
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped before bready");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped before rready");
	a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready stayed high after address taken");
	a_standby_gate: assert property (analog_shutdown_q |-> !clocks_run_q)
		else $error("clocks run during shutdown");
	a_standby_kept: assert property (analog_shutdown_q && bus_supply |-> !boost_stop_q)
		else $error("boost stopped with bus supply present");
	a_off_cond: assert property ($rose(boost_stop_q) |-> !bus_supply && !onoff_on)
		else $error("boost stopped while supply or switch on");
	a_grace_span: assert property ($rose(analog_shutdown_q) |-> gap_q >= 6'h1c)
		else $error("shutdown came before grace period");
	a_halt_first: assert property ($rose(analog_shutdown_q) |-> $past(cpu_halted, 2))
		else $error("shutdown without halted core");
	a_forced_off: assert property (analog_shutdown_q |->
		!fast_osc_enable_q && !slow_osc_enable_q && card_power_off_q)
		else $error("enables not forced off in shutdown");
	a_wake_delay: assert property ($rose(wake_interrupt_line_q) |-> run_q >= 10'h1fc)
		else $error("wake line before warm count");
	a_wake_bound: assert property ($rose(clocks_run_q) |-> ##[508:530] wake_interrupt_line_q)
		else $error("wake line late after restart");
	a_read_clear: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == EXT
		|=> !wake_interrupt_line_q)
		else $error("wake line kept after control read");
endmodule

bind pdwc_top pdwc_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.bus_supply(bus_supply), .onoff_on(onoff_on), .cpu_halted(cpu_halted),
	.clocks_run_q(clocks_run_q), .analog_shutdown_q(analog_shutdown_q),
	.boost_stop_q(boost_stop_q), .slow_osc_enable_q(slow_osc_enable_q),
	.fast_osc_enable_q(fast_osc_enable_q), .card_power_off_q(card_power_off_q),
	.wake_interrupt_line_q(wake_interrupt_line_q));

// *** pdwc_regs.vh ***
`ifndef PDWC_REGS_VH
`define PDWC_REGS_VH

`define PDWC_ADDR_W         18
`define PDWC_IDX_W          16
`define PDWC_IDX_EXT_CTRL   16'hff94
`define PDWC_IDX_MISC0      16'hfff1
`define PDWC_IDX_MISC1      16'hfff2
`define PDWC_IDX_PWR_EN     16'hff00
`define PDWC_IDX_STATUS     16'hff01

`define PDWC_RST_EXT_CTRL   8'h00
`define PDWC_RST_MISC0      8'h00
`define PDWC_RST_MISC1      8'h10
`define PDWC_RST_PWR_EN     8'h0d

`define PDWC_MASK_EXT_CTRL  8'hbf
`define PDWC_MASK_MISC0     8'h80
`define PDWC_MASK_MISC1     8'h37
`define PDWC_MASK_PWR_EN    8'h1f

`define PDWC_EXT_ROUTE      7
`define PDWC_EXT_RTC_EN     5
`define PDWC_EXT_RTC_FLAG   4
`define PDWC_EXT_USB_EN     3
`define PDWC_EXT_USB_FLAG   2
`define PDWC_EXT_KP_EN      1
`define PDWC_EXT_KP_FLAG    0
`define PDWC_M0_PDREQ       7
`define PDWC_M1_FLASH_PS    5
`define PDWC_M1_ANALOG      2
`define PDWC_M1_USB_XCVR    1
`define PDWC_M1_USB_CONN    0
`define PDWC_PE_VDDF        0
`define PDWC_PE_CMP         1
`define PDWC_PE_SLOW_OSC    2
`define PDWC_PE_FAST_OSC    3
`define PDWC_PE_CARD_OFF    4

`define PDWC_GRACE_CYC      10'd32
`define PDWC_WARM_CYC       10'd512
`define PDWC_TMR_W          10

`endif

// *** pdwc_timer.v ***
`timescale 1ns/1ps
`include "pdwc_regs.vh"

// Down counter that pulses done a set number of cycles after start.
module pdwc_timer #(
	parameter W = `PDWC_TMR_W
) (
	input  wire         clk_sys,
	input  wire         rstn,
	input  wire         start,
	input  wire [W-1:0] load,
	output reg          done_q
);

	reg [W-1:0] count_q;

	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			count_q <= {W{1'b0}};
			done_q  <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (start)
				count_q <= load;
			else if (count_q != {W{1'b0}})
			begin
				count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
				done_q  <= (count_q == {{(W-1){1'b0}}, 1'b1});
			end
		end
	end

endmodule

// *** pdwc_top.v ***
`timescale 1ns/1ps
`include "pdwc_regs.vh"

module pdwc_top (
	input  wire                    clk_sys,
	input  wire                    rstn,
	input  wire                    s_axi_awvalid,
	output reg                     s_axi_awready,
	input  wire [`PDWC_ADDR_W-1:0] s_axi_awaddr,
	input  wire                    s_axi_wvalid,
	output reg                     s_axi_wready,
	input  wire [31:0]             s_axi_wdata,
	input  wire [3:0]              s_axi_wstrb,
	output reg                     s_axi_bvalid,
	input  wire                    s_axi_bready,
	output reg  [1:0]              s_axi_bresp,
	input  wire                    s_axi_arvalid,
	output reg                     s_axi_arready,
	input  wire [`PDWC_ADDR_W-1:0] s_axi_araddr,
	output reg                     s_axi_rvalid,
	input  wire                    s_axi_rready,
	output reg  [31:0]             s_axi_rdata,
	output reg  [1:0]              s_axi_rresp,
	input  wire                    bus_supply,
	input  wire                    onoff_on,
	input  wire [7:0]              user_io_pins,
	input  wire                    card_irq,
	input  wire                    rtc_irq,
	input  wire                    usb_irq,
	input  wire                    keypad_irq,
	input  wire                    cpu_halted,
	output reg                     clocks_run_q,
	output reg                     analog_shutdown_q,
	output reg                     boost_stop_q,
	output reg                     analog_block_enable_q,
	output reg                     supply_fault_enable_q,
	output reg                     comparator_enable_q,
	output reg                     slow_osc_enable_q,
	output reg                     fast_osc_enable_q,
	output reg                     card_power_off_q,
	output reg                     usb_transceiver_enable_q,
	output reg                     usb_connect_q,
	output reg                     flash_pulse_shortener_enable_q,
	output reg                     wake_interrupt_line_q
);

	localparam [2:0] ST_RUN     = 3'd0;
	localparam [2:0] ST_GRACE   = 3'd1;
	localparam [2:0] ST_STANDBY = 3'd2;
	localparam [2:0] ST_OFF     = 3'd3;
	localparam [2:0] ST_WARM    = 3'd4;

	localparam [2:0] SEL_NONE = 3'd0;
	localparam [2:0] SEL_EXT  = 3'd1;
	localparam [2:0] SEL_M0   = 3'd2;
	localparam [2:0] SEL_M1   = 3'd3;
	localparam [2:0] SEL_PWR  = 3'd4;
	localparam [2:0] SEL_STAT = 3'd5;

	// Maps a word-aligned byte address onto a register selector.
	function [2:0] reg_sel;
		input [`PDWC_ADDR_W-1:0] addr;
		begin
			reg_sel = SEL_NONE;
			if (addr[1:0] == 2'h0)
			begin
				case (addr[`PDWC_ADDR_W-1:2])
					`PDWC_IDX_EXT_CTRL: reg_sel = SEL_EXT;
					`PDWC_IDX_MISC0:    reg_sel = SEL_M0;
					`PDWC_IDX_MISC1:    reg_sel = SEL_M1;
					`PDWC_IDX_PWR_EN:   reg_sel = SEL_PWR;
					`PDWC_IDX_STATUS:   reg_sel = SEL_STAT;
					default:            reg_sel = SEL_NONE;
				endcase
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	reg [9:0] pin_meta_q;
	reg [9:0] pin_sync_q;

	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_meta_q <= 10'h000;
			pin_sync_q <= 10'h000;
		end
		else
		begin
			pin_meta_q <= {bus_supply, onoff_on, user_io_pins};
			pin_sync_q <= pin_meta_q;
		end
	end

	wire bus_supply_s = pin_sync_q[9];
	wire onoff_on_s   = pin_sync_q[8];
	wire user_irq_s   = |pin_sync_q[7:0];

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes.

	reg                    aw_held_q;
	reg                    w_held_q;
	reg [`PDWC_ADDR_W-1:0] awaddr_q;
	reg [7:0]              wdata_q;
	reg                    wstrb_q;

	wire aw_take  = s_axi_awvalid & s_axi_awready;
	wire w_take   = s_axi_wvalid & s_axi_wready;
	wire do_wr    = aw_held_q & w_held_q & ~s_axi_bvalid;
	wire aw_held_d = (aw_held_q | aw_take) & ~do_wr;
	wire w_held_d  = (w_held_q | w_take) & ~do_wr;
	wire bvalid_d  = do_wr | (s_axi_bvalid & ~s_axi_bready);
	wire ar_take   = s_axi_arvalid & s_axi_arready;
	wire rvalid_d  = ar_take | (s_axi_rvalid & ~s_axi_rready);
	wire [2:0] wsel = reg_sel(awaddr_q);
	wire [2:0] rsel = reg_sel(s_axi_araddr);
	wire wr_en     = do_wr & wstrb_q;

	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= {`PDWC_ADDR_W{1'b0}};
			wdata_q       <= 8'h00;
			wstrb_q       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
		end
		else
		begin
			aw_held_q     <= aw_held_d;
			w_held_q      <= w_held_d;
			s_axi_awready <= ~aw_held_d & ~bvalid_d;
			s_axi_wready  <= ~w_held_d & ~bvalid_d;
			s_axi_bvalid  <= bvalid_d;
			s_axi_arready <= ~rvalid_d;
			s_axi_rvalid  <= rvalid_d;
			if (aw_take)
				awaddr_q <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_q <= s_axi_wdata[7:0];
				wstrb_q <= s_axi_wstrb[0];
			end
			if (do_wr)
				s_axi_bresp <= (wsel == SEL_NONE) ? 2'h2 : 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers and wake sources.

	reg [7:0] ext_ctrl_q;
	reg [7:0] misc0_q;
	reg [7:0] misc1_q;
	reg [7:0] pwr_en_q;
	reg [2:0] state_q;
	reg       grace_over_q;

	wire ext_wr  = wr_en & (wsel == SEL_EXT);
	wire ext_rd  = ar_take & (rsel == SEL_EXT);
	wire pdreq   = misc0_q[`PDWC_M0_PDREQ];
	wire route   = ext_ctrl_q[`PDWC_EXT_ROUTE];
	wire wake_src = user_irq_s | card_irq
		| (ext_ctrl_q[`PDWC_EXT_RTC_FLAG] & ext_ctrl_q[`PDWC_EXT_RTC_EN])
		| (ext_ctrl_q[`PDWC_EXT_USB_FLAG] & ext_ctrl_q[`PDWC_EXT_USB_EN])
		| (ext_ctrl_q[`PDWC_EXT_KP_FLAG] & ext_ctrl_q[`PDWC_EXT_KP_EN]);

	wire standby_wake = (state_q == ST_STANDBY) & wake_src;
	wire route_wake   = (state_q == ST_RUN) & ~pdreq & route & wake_src
		& ~wake_interrupt_line_q;
	wire grace_start  = (state_q == ST_RUN) & pdreq;
	wire tmr_start    = grace_start | standby_wake | route_wake;
	wire tmr_done;

	pdwc_timer #(
		.W (`PDWC_TMR_W)
	) u_timer (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.start   (tmr_start),
		.load    (grace_start ? `PDWC_GRACE_CYC : `PDWC_WARM_CYC),
		.done_q  (tmr_done)
	);

	// Flags are set by their event and cleared by writing zero; the event wins.
	function flag_next;
		input flag;
		input event_in;
		input clr;
		begin
			flag_next = event_in | (flag & ~clr);
		end
	endfunction

	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			ext_ctrl_q <= `PDWC_RST_EXT_CTRL;
			misc0_q    <= `PDWC_RST_MISC0;
			misc1_q    <= `PDWC_RST_MISC1;
			pwr_en_q   <= `PDWC_RST_PWR_EN;
		end
		else
		begin
			if (ext_wr)
				ext_ctrl_q[`PDWC_EXT_ROUTE] <= wdata_q[`PDWC_EXT_ROUTE];
			else if (ext_rd)
				ext_ctrl_q[`PDWC_EXT_ROUTE] <= 1'b0;
			if (ext_wr)
			begin
				ext_ctrl_q[`PDWC_EXT_RTC_EN] <= wdata_q[`PDWC_EXT_RTC_EN];
				ext_ctrl_q[`PDWC_EXT_USB_EN] <= wdata_q[`PDWC_EXT_USB_EN];
				ext_ctrl_q[`PDWC_EXT_KP_EN]  <= wdata_q[`PDWC_EXT_KP_EN];
			end
			ext_ctrl_q[`PDWC_EXT_RTC_FLAG] <= flag_next(ext_ctrl_q[`PDWC_EXT_RTC_FLAG], rtc_irq,
				ext_wr & ~wdata_q[`PDWC_EXT_RTC_FLAG]);
			ext_ctrl_q[`PDWC_EXT_USB_FLAG] <= flag_next(ext_ctrl_q[`PDWC_EXT_USB_FLAG], usb_irq,
				ext_wr & ~wdata_q[`PDWC_EXT_USB_FLAG]);
			ext_ctrl_q[`PDWC_EXT_KP_FLAG] <= flag_next(ext_ctrl_q[`PDWC_EXT_KP_FLAG], keypad_irq,
				ext_wr & ~wdata_q[`PDWC_EXT_KP_FLAG]);
			if (standby_wake)
				misc0_q <= 8'h00;
			else if (wr_en & (wsel == SEL_M0))
				misc0_q <= wdata_q & `PDWC_MASK_MISC0;
			if (wr_en & (wsel == SEL_M1))
				misc1_q <= wdata_q & `PDWC_MASK_MISC1;
			if (wr_en & (wsel == SEL_PWR))
				pwr_en_q <= wdata_q & `PDWC_MASK_PWR_EN;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power sequencing.

	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q      <= ST_RUN;
			grace_over_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_RUN:
				begin
					grace_over_q <= 1'b0;
					if (grace_start)
						state_q <= ST_GRACE;
					else if (route_wake)
						state_q <= ST_WARM;
				end
				ST_GRACE:
				begin
					if (tmr_done)
						grace_over_q <= 1'b1;
					if (!pdreq)
						state_q <= ST_RUN;
					else if ((grace_over_q | tmr_done) & cpu_halted)
						state_q <= (bus_supply_s | onoff_on_s) ? ST_STANDBY : ST_OFF;
				end
				ST_STANDBY:
				begin
					if (standby_wake)
						state_q <= ST_WARM;
				end
				ST_WARM:
				begin
					if (tmr_done)
						state_q <= ST_RUN;
				end
				ST_OFF:
					state_q <= ST_OFF;
				default:
					state_q <= ST_RUN;
			endcase
		end
	end

	wire shut = (state_q == ST_STANDBY) | (state_q == ST_OFF);

	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			clocks_run_q                   <= 1'b1;
			analog_shutdown_q              <= 1'b0;
			boost_stop_q                   <= 1'b0;
			analog_block_enable_q          <= 1'b0;
			supply_fault_enable_q          <= 1'b0;
			comparator_enable_q            <= 1'b0;
			slow_osc_enable_q              <= 1'b0;
			fast_osc_enable_q              <= 1'b0;
			card_power_off_q               <= 1'b1;
			usb_transceiver_enable_q       <= 1'b0;
			usb_connect_q                  <= 1'b0;
			flash_pulse_shortener_enable_q <= 1'b0;
			wake_interrupt_line_q          <= 1'b0;
		end
		else
		begin
			clocks_run_q          <= ~shut;
			analog_shutdown_q     <= shut;
			boost_stop_q          <= (state_q == ST_OFF);
			analog_block_enable_q <= misc1_q[`PDWC_M1_ANALOG] & ~shut;
			supply_fault_enable_q <= pwr_en_q[`PDWC_PE_VDDF] & ~shut;
			comparator_enable_q   <= pwr_en_q[`PDWC_PE_CMP] & ~shut;
			slow_osc_enable_q     <= pwr_en_q[`PDWC_PE_SLOW_OSC] & ~shut;
			fast_osc_enable_q     <= pwr_en_q[`PDWC_PE_FAST_OSC] & ~shut;
			card_power_off_q      <= pwr_en_q[`PDWC_PE_CARD_OFF] | shut;
			usb_transceiver_enable_q <= misc1_q[`PDWC_M1_USB_XCVR] & ~shut;
			usb_connect_q         <= misc1_q[`PDWC_M1_USB_CONN];
			flash_pulse_shortener_enable_q <= misc1_q[`PDWC_M1_FLASH_PS] | shut;
			if ((state_q == ST_WARM) & tmr_done)
				wake_interrupt_line_q <= 1'b1;
			else if (ext_rd)
				wake_interrupt_line_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data.

	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else if (ar_take)
		begin
			s_axi_rresp <= (rsel == SEL_NONE) ? 2'h2 : 2'h0;
			case (rsel)
				SEL_EXT:  s_axi_rdata <= {24'h000000, ext_ctrl_q};
				SEL_M0:   s_axi_rdata <= {24'h000000, misc0_q};
				SEL_M1:   s_axi_rdata <= {24'h000000, misc1_q};
				SEL_PWR:  s_axi_rdata <= {24'h000000, pwr_en_q};
				SEL_STAT: s_axi_rdata <= {26'h0, wake_interrupt_line_q, onoff_on_s,
					bus_supply_s, state_q};
				default:  s_axi_rdata <= 32'h00000000;
			endcase
		end
	end

endmodule

// *** power_down_wake_controller_bench.sv ***
`timescale 1ns/1ps
`include "pdwc_regs.vh"

module power_down_wake_controller_bench;
	reg        clk_sys = 1'h0, rstn = 1'h0, bus_supply = 1'h1, onoff_on = 1'h0;
	reg        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	reg        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cpu_halted = 1'h0;
	reg        card_irq = 1'h0, rtc_irq = 1'h0, usb_irq = 1'h0, keypad_irq = 1'h0;
	reg [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
	reg [31:0] s_axi_wdata = 32'h00000000;
	reg [3:0]  s_axi_wstrb = 4'h0;
	reg [7:0]  user_io_pins = 8'h00;
	wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire       clocks_run_q, analog_shutdown_q, boost_stop_q, analog_block_enable_q;
	wire       supply_fault_enable_q, comparator_enable_q, slow_osc_enable_q, fast_osc_enable_q;
	wire       card_power_off_q, usb_transceiver_enable_q, usb_connect_q;
	wire       flash_pulse_shortener_enable_q, wake_interrupt_line_q;
	int        error_cnt = 0, checks = 0, n;

	pdwc_top uut (
		.clk_sys(clk_sys), .rstn(rstn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.bus_supply(bus_supply), .onoff_on(onoff_on), .user_io_pins(user_io_pins),
		.card_irq(card_irq), .rtc_irq(rtc_irq), .usb_irq(usb_irq), .keypad_irq(keypad_irq),
		.cpu_halted(cpu_halted),
		.clocks_run_q(clocks_run_q), .analog_shutdown_q(analog_shutdown_q),
		.boost_stop_q(boost_stop_q), .analog_block_enable_q(analog_block_enable_q),
		.supply_fault_enable_q(supply_fault_enable_q),
		.comparator_enable_q(comparator_enable_q),
		.slow_osc_enable_q(slow_osc_enable_q), .fast_osc_enable_q(fast_osc_enable_q),
		.card_power_off_q(card_power_off_q),
		.usb_transceiver_enable_q(usb_transceiver_enable_q),
		.usb_connect_q(usb_connect_q),
		.flash_pulse_shortener_enable_q(flash_pulse_shortener_enable_q),
		.wake_interrupt_line_q(wake_interrupt_line_q)
	);

	always #20 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input [31:0] e, input [31:0] g);
	begin
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	end
	endtask

	task cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task automatic wr(input [15:0] i, input [7:0] d, input [1:0] r);
		int k;
	begin
		k = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge clk_sys);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk("bvalid", 1, s_axi_bvalid);
		chk("b_wait", 3, k);
		chk("bresp", r, s_axi_bresp);
	end
	endtask

	task automatic rd(input [15:0] i, input [7:0] d, input [1:0] r);
		int k;
	begin
		k = 0;
		@(posedge clk_sys);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge clk_sys);
			k++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk("rdata", {24'h000000, d}, s_axi_rdata);
		chk("rresp", r, s_axi_rresp);
		chk("r_wait", 2, k);
	end
	endtask

	// Counts cycles until the wake line goes high.
	task wt;
	begin
		n = 0;
		while (wake_interrupt_line_q !== 1'h1 && n < 700)
		begin
			@(posedge clk_sys);
			n++;
		end
	end
	endtask

	task summarize;
	begin
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		cyc(4000);
		error_cnt++;
		summarize;
	end

	initial
	begin
		cyc(20);
		rstn <= 1'h1;
		cyc(2);
		rd(`PDWC_IDX_EXT_CTRL, 8'h00, 2'h0);
		rd(`PDWC_IDX_MISC0, 8'h00, 2'h0);
		rd(`PDWC_IDX_MISC1, 8'h10, 2'h0);
		rd(`PDWC_IDX_PWR_EN, 8'h0d, 2'h0);
		rd(16'h0123, 8'h00, 2'h2);
		wr(16'h0123, 8'hff, 2'h2);
		chk("clocks_run", 1, clocks_run_q);
		wr(`PDWC_IDX_EXT_CTRL, 8'haa, 2'h0);
		rd(`PDWC_IDX_EXT_CTRL, 8'haa, 2'h0);
		rd(`PDWC_IDX_EXT_CTRL, 8'h2a, 2'h0);
		// Routed USB event while running raises the wake line after the warm count.
		wr(`PDWC_IDX_EXT_CTRL, 8'h88, 2'h0);
		usb_irq <= 1'h1;
		cyc(1);
		usb_irq <= 1'h0;
		wt;
		chk("route_delay", 1, n >= 508 && n <= 518);
		rd(`PDWC_IDX_EXT_CTRL, 8'h8c, 2'h0);
		cyc(2);
		chk("line_cleared", 0, wake_interrupt_line_q);
		// Standby with bus supply present.
		wr(`PDWC_IDX_PWR_EN, 8'h0f, 2'h0);
		wr(`PDWC_IDX_MISC1, 8'h17, 2'h0);
		cyc(2);
		chk("fast_osc_on", 1, fast_osc_enable_q);
		chk("card_on", 0, card_power_off_q);
		chk("usb_conn", 1, usb_connect_q);
		// Route select is set first, and the stale USB flag is cleared so it cannot wake.
		wr(`PDWC_IDX_EXT_CTRL, 8'h88, 2'h0);
		wr(`PDWC_IDX_MISC0, 8'h80, 2'h0);
		cyc(40);
		chk("run_unhalted", 1, clocks_run_q);
		cpu_halted <= 1'h1;
		cyc(6);
		chk("standby_clk", 0, clocks_run_q);
		chk("standby_ana", 1, analog_shutdown_q);
		chk("standby_boost", 0, boost_stop_q);
		chk("fast_osc_off", 0, fast_osc_enable_q);
		chk("slow_osc_off", 0, slow_osc_enable_q);
		chk("vddf_off", 0, supply_fault_enable_q);
		chk("cmp_off", 0, comparator_enable_q);
		chk("ana_blk_off", 0, analog_block_enable_q);
		chk("usb_suspend", 0, usb_transceiver_enable_q);
		chk("card_off", 1, card_power_off_q);
		chk("flash_bypass", 1, flash_pulse_shortener_enable_q);
		user_io_pins <= 8'h04;
		cpu_halted <= 1'h0;
		n = 0;
		while (clocks_run_q !== 1'h1 && n < 20)
		begin
			cyc(1);
			n++;
		end
		user_io_pins <= 8'h00;
		chk("wake_clk", 1, clocks_run_q);
		wt;
		chk("warm_delay", 1, n >= 508 && n <= 518);
		chk("fast_osc_back", 1, fast_osc_enable_q);
		chk("card_back", 0, card_power_off_q);
		rd(`PDWC_IDX_MISC0, 8'h00, 2'h0);
		rd(`PDWC_IDX_EXT_CTRL, 8'h88, 2'h0);
		rd(`PDWC_IDX_EXT_CTRL, 8'h08, 2'h0);
		// Event pulses set the RTC and keypad flags even with their enables off.
		rtc_irq <= 1'h1;
		keypad_irq <= 1'h1;
		cyc(1);
		rtc_irq <= 1'h0;
		keypad_irq <= 1'h0;
		rd(`PDWC_IDX_EXT_CTRL, 8'h19, 2'h0);
		// Power-down with neither bus supply nor switch on turns the chip off.
		bus_supply <= 1'h0;
		cpu_halted <= 1'h1;
		cyc(4);
		wr(`PDWC_IDX_MISC0, 8'h80, 2'h0);
		cyc(45);
		chk("off_boost", 1, boost_stop_q);
		chk("off_clk", 0, clocks_run_q);
		rd(`PDWC_IDX_STATUS, 8'h03, 2'h0);
		summarize;
	end
endmodule
